// [hw/port_pin_config.sv]
// pin configuration registers, pad control and external interrupt logic of ports 0 to 2
// Function
// - second external interrupt enable at bit 3
// - bit 2 second pending, write zero clears
// - first external interrupt enable at bit 1
// - bit 0 first pending, write zero clears
// - port1 bit 7 selects pin1 open-drain
// - port1 bit 6 selects pin0 open-drain
// - port1 bits 3:2 configure pin1 mode
// - port1 bits 1:0 configure pin0 mode
// - port2 high bits 6:4 configure pin6
// - port2 high bits 3:2 configure pin5
// - port2 high bits 1:0 configure pin4
// - port2 low fields configure pins 3..0
// - port2 pin0 code 11 outputs timer match
// - port0 pins 0,1 interrupt when Schmitt input
// - pending bit sticks until software clears
module port_pin_config
  import port_cfg_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // register file access
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // port 0 interrupt pins and their configuration from the port 0 block
  input  wire logic [1:0] port0_pad_in_i,
  input  wire logic [7:0] port0_config_low_i,
  // output data and alternate sources
  input  wire logic [1:0] port1_data_i,
  input  wire logic [6:0] port2_data_i,
  input  wire logic       timer_zero_match_i,
  input  wire logic       clock_output_i,
  // port 1 pads
  input  wire logic [1:0] port1_pad_in_i,
  output logic      [1:0] port1_pad_out_o,
  output logic      [1:0] port1_pad_oe_o,
  output logic      [1:0] port1_pullup_o,
  output logic      [1:0] port1_pulldown_o,
  output logic      [1:0] port1_pin_o,
  // port 2 pads
  input  wire logic [6:0] port2_pad_in_i,
  output logic      [6:0] port2_pad_out_o,
  output logic      [6:0] port2_pad_oe_o,
  output logic      [6:0] port2_pullup_o,
  output logic      [6:0] port2_pin_o,
  output logic            analog_input_eight_en_o,
  // interrupt request
  output logic            ext_irq_o
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] port1_config_q;
  logic [7:0] port2_config_high_q;
  logic [7:0] port2_config_low_q;
  logic [1:0] irq_enable_q;
  logic [1:0] irq_pending;

  logic       sel_p0;
  logic       sel_p1;
  logic       sel_p2h;
  logic       sel_p2l;
  logic       wr_p0;
  logic [7:0] rd_mux;

  assign sel_p0  = (reg_addr_i == OFS_PORT0_EXT_IRQ_CTRL);
  assign sel_p1  = (reg_addr_i == OFS_PORT1_CONFIG);
  assign sel_p2h = (reg_addr_i == OFS_PORT2_CONFIG_HIGH);
  assign sel_p2l = (reg_addr_i == OFS_PORT2_CONFIG_LOW);
  assign wr_p0   = reg_wr_i && sel_p0;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port1_config_q      <= RST_PORT1_CONFIG;
      port2_config_high_q <= RST_PORT2_CONFIG_HIGH;
      port2_config_low_q  <= RST_PORT2_CONFIG_LOW;
    end else if (reg_wr_i) begin
      if (sel_p1) begin
        port1_config_q <= reg_wdata_i & MASK_PORT1_CONFIG;
      end
      if (sel_p2h) begin
        port2_config_high_q <= reg_wdata_i & MASK_PORT2_CONFIG_HIGH;
      end
      if (sel_p2l) begin
        port2_config_low_q <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // external interrupts on port 0 pins 0 and 1
  // ----------------------------------------------------------------
  // bit positions of each source's fields in the control bytes
  localparam int EN_BIT  [2] = '{BIT_EXT_IRQ0_ENABLE, BIT_EXT_IRQ1_ENABLE};
  localparam int PND_BIT [2] = '{BIT_EXT_IRQ0_PENDING, BIT_EXT_IRQ1_PENDING};
  localparam int CFG_LSB [2] = '{LSB_P0_PIN0_CFG, LSB_P0_PIN1_CFG};

  // enable bits, software owned; one process keeps one driver
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_enable_q <= {2{RST_IRQ_ENABLE}};
    end else if (wr_p0) begin
      irq_enable_q <= {reg_wdata_i[EN_BIT[1]], reg_wdata_i[EN_BIT[0]]};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ext_irq
      logic schmitt_in;
      logic clear;

      // edges count only in Schmitt modes
      assign schmitt_in = ~port0_config_low_i[CFG_LSB[gi] + 1];
      assign clear      = wr_p0 && !reg_wdata_i[PND_BIT[gi]];

      ext_irq_edge u_edge (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pad_in_i  (port0_pad_in_i[gi]),
        .edge_en_i (irq_enable_q[gi] && schmitt_in),
        .clear_i   (clear),
        .pending_o (irq_pending[gi])
      );
    end
  endgenerate

  // one request line for both sources
  assign ext_irq_o = |(irq_pending & irq_enable_q);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] p0_view;

  assign p0_view = {4'h0,
                    irq_enable_q[1], irq_pending[1],
                    irq_enable_q[0], irq_pending[0]};

  // unmapped addresses read zero so the block can share the file with others
  assign rd_mux = sel_p0  ? (p0_view & MASK_PORT0_EXT_IRQ_CTRL) :
                  sel_p1  ? port1_config_q :
                  sel_p2h ? port2_config_high_q :
                  sel_p2l ? port2_config_low_q : 8'h00;

  // a read beside a write returns the old value; the new one shows next read
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // the open-drain bit only matters once the field selects an output
  function automatic pin_mode_t dec_p1(input logic [1:0] cfg, input logic open_drain);
    pin_mode_t m;
    m = MODE_IN;
    case (cfg)
      P1_CFG_IN:    m = MODE_IN;
      P1_CFG_IN_PU: m = MODE_IN_PU;
      P1_CFG_OUT:   m = open_drain ? MODE_OD : MODE_PP;
      P1_CFG_IN_PD: m = MODE_IN_PD;
      default:      m = MODE_IN;
    endcase
    return m;
  endfunction : dec_p1

  function automatic pin_mode_t dec_p2(input logic [1:0] cfg);
    pin_mode_t m;
    m = MODE_IN_PU;
    case (cfg)
      P2_CFG_IN_PU: m = MODE_IN_PU;
      P2_CFG_IN:    m = MODE_IN;
      P2_CFG_PP:    m = MODE_PP;
      P2_CFG_OD:    m = MODE_OD;
      default:      m = MODE_IN_PU;
    endcase
    return m;
  endfunction : dec_p2

  function automatic pin_mode_t dec_p26(input logic [2:0] cfg);
    pin_mode_t m;
    m = MODE_IN_PU;
    if (cfg[2:1] == P26_CFG_ANALOG) begin
      m = MODE_ANALOG;
    end else begin
      case (cfg)
        P26_CFG_IN_PU:   m = MODE_IN_PU;
        P26_CFG_IN:      m = MODE_IN;
        P26_CFG_PP:      m = MODE_PP;
        P26_CFG_OD_PU:   m = MODE_OD_PU;
        P26_CFG_OD:      m = MODE_OD;
        P26_CFG_CLK_OUT: m = MODE_PP;
        default:         m = MODE_IN_PU;
      endcase
    end
    return m;
  endfunction : dec_p26

  pin_mode_t  p1_mode [2];
  pin_mode_t  p2_mode [7];
  logic [1:0] p2_field [6];
  logic       p2_pin0_timer;
  logic       p2_pin6_clock;
  logic [6:0] p2_drive;

  // pin 0 mode and driver type
  assign p1_mode[0] = dec_p1(port1_config_q[LSB_P1_PIN0_CFG +: 2],
                             port1_config_q[BIT_P1_PIN0_OPEN_DRN]);
  // pin 1 mode and driver type
  assign p1_mode[1] = dec_p1(port1_config_q[LSB_P1_PIN1_CFG +: 2],
                             port1_config_q[BIT_P1_PIN1_OPEN_DRN]);

  assign p2_field[0] = port2_config_low_q[LSB_P2_PIN0_CFG +: 2];
  assign p2_field[1] = port2_config_low_q[LSB_P2_PIN1_CFG +: 2];
  assign p2_field[2] = port2_config_low_q[LSB_P2_PIN2_CFG +: 2];
  assign p2_field[3] = port2_config_low_q[LSB_P2_PIN3_CFG +: 2];
  // high byte fields, pins 4 and 5
  assign p2_field[4] = port2_config_high_q[LSB_P2_PIN4_CFG +: 2];
  assign p2_field[5] = port2_config_high_q[LSB_P2_PIN5_CFG +: 2];

  generate
    for (gi = 0; gi < 6; gi++) begin : g_p2_dec
      if (gi == 0) begin : g_pin0
        // code 11 drives the timer match push-pull instead of open drain
        assign p2_mode[gi] = (p2_field[gi] == P2_CFG_T0_MATCH) ? MODE_PP
                                                              : dec_p2(p2_field[gi]);
      end else begin : g_pinx
        assign p2_mode[gi] = dec_p2(p2_field[gi]);
      end
    end
  endgenerate

  assign p2_mode[6]    = dec_p26(port2_config_high_q[LSB_P2_PIN6_CFG +: 3]);
  assign p2_pin0_timer = (p2_field[0] == P2_CFG_T0_MATCH);
  assign p2_pin6_clock = (port2_config_high_q[LSB_P2_PIN6_CFG +: 3] == P26_CFG_CLK_OUT);

  // alternate functions replace the port data on their pins
  assign p2_drive = {p2_pin6_clock ? clock_output_i : port2_data_i[6],
                     port2_data_i[5:1],
                     p2_pin0_timer ? timer_zero_match_i : port2_data_i[0]};

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  logic [6:0] p2_analog;
  logic [6:0] p2_pulldown;
  logic [1:0] p1_analog;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_p1_pin
      pin_cell u_pin (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .mode_i      (p1_mode[gi]),
        .data_i      (port1_data_i[gi]),
        .pad_in_i    (port1_pad_in_i[gi]),
        .pad_out_o   (port1_pad_out_o[gi]),
        .pad_oe_o    (port1_pad_oe_o[gi]),
        .pullup_o    (port1_pullup_o[gi]),
        .pulldown_o  (port1_pulldown_o[gi]),
        .analog_en_o (p1_analog[gi]),
        .pin_o       (port1_pin_o[gi])
      );
    end
    for (gi = 0; gi < 7; gi++) begin : g_p2_pin
      pin_cell u_pin (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .mode_i      (p2_mode[gi]),
        .data_i      (p2_drive[gi]),
        .pad_in_i    (port2_pad_in_i[gi]),
        .pad_out_o   (port2_pad_out_o[gi]),
        .pad_oe_o    (port2_pad_oe_o[gi]),
        .pullup_o    (port2_pullup_o[gi]),
        .pulldown_o  (p2_pulldown[gi]),
        .analog_en_o (p2_analog[gi]),
        .pin_o       (port2_pin_o[gi])
      );
    end
  endgenerate

  // only pin 6 of port 2 has an analog path; port 2 pulldowns never engage
  assign analog_input_eight_en_o = p2_analog[6];

endmodule : port_pin_config

// [hw/port_cfg_pkg.sv]
// constants, field layouts and pin modes shared by the port configuration block
package port_cfg_pkg;

  // ----------------------------------------------------------------
  // register offsets in the register file
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT0_EXT_IRQ_CTRL = 8'hE8;
  localparam logic [7:0] OFS_PORT1_CONFIG       = 8'hE9;
  localparam logic [7:0] OFS_PORT2_CONFIG_HIGH  = 8'hEA;
  localparam logic [7:0] OFS_PORT2_CONFIG_LOW   = 8'hEB;

  // ----------------------------------------------------------------
  // implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_PORT0_EXT_IRQ_CTRL = 8'h0F;
  localparam logic [7:0] MASK_PORT1_CONFIG       = 8'hCF;
  localparam logic [7:0] MASK_PORT2_CONFIG_HIGH  = 8'h7F;
  localparam logic [7:0] MASK_PORT2_CONFIG_LOW   = 8'hFF;
  localparam logic [7:0] RST_PORT1_CONFIG        = 8'h00;
  localparam logic [7:0] RST_PORT2_CONFIG_HIGH   = 8'h00;
  localparam logic [7:0] RST_PORT2_CONFIG_LOW    = 8'h00;
  localparam logic       RST_IRQ_ENABLE          = 1'b0;
  localparam logic       RST_IRQ_PENDING         = 1'b0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_EXT_IRQ0_PENDING = 0;
  localparam int BIT_EXT_IRQ0_ENABLE  = 1;
  localparam int BIT_EXT_IRQ1_PENDING = 2;
  localparam int BIT_EXT_IRQ1_ENABLE  = 3;
  localparam int BIT_P1_PIN0_OPEN_DRN = 6;
  localparam int BIT_P1_PIN1_OPEN_DRN = 7;
  localparam int LSB_P1_PIN0_CFG      = 0;
  localparam int LSB_P1_PIN1_CFG      = 2;
  localparam int LSB_P2_PIN4_CFG      = 0;
  localparam int LSB_P2_PIN5_CFG      = 2;
  localparam int LSB_P2_PIN6_CFG      = 4;
  localparam int LSB_P2_PIN0_CFG      = 0;
  localparam int LSB_P2_PIN1_CFG      = 2;
  localparam int LSB_P2_PIN2_CFG      = 4;
  localparam int LSB_P2_PIN3_CFG      = 6;
  localparam int LSB_P0_PIN0_CFG      = 0;
  localparam int LSB_P0_PIN1_CFG      = 2;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] P1_CFG_IN       = 2'h0;
  localparam logic [1:0] P1_CFG_IN_PU    = 2'h1;
  localparam logic [1:0] P1_CFG_OUT      = 2'h2;
  localparam logic [1:0] P1_CFG_IN_PD    = 2'h3;
  localparam logic [1:0] P2_CFG_IN_PU    = 2'h0;
  localparam logic [1:0] P2_CFG_IN       = 2'h1;
  localparam logic [1:0] P2_CFG_PP       = 2'h2;
  localparam logic [1:0] P2_CFG_OD       = 2'h3;
  localparam logic [1:0] P2_CFG_T0_MATCH = 2'h3;
  localparam logic [2:0] P26_CFG_IN_PU   = 3'h0;
  localparam logic [2:0] P26_CFG_IN      = 3'h1;
  localparam logic [1:0] P26_CFG_ANALOG  = 2'h1;
  localparam logic [2:0] P26_CFG_PP      = 3'h4;
  localparam logic [2:0] P26_CFG_OD_PU   = 3'h5;
  localparam logic [2:0] P26_CFG_OD      = 3'h6;
  localparam logic [2:0] P26_CFG_CLK_OUT = 3'h7;

  // electrical role of one pin
  typedef enum logic [2:0] {
    MODE_IN_PU  = 3'h0,
    MODE_IN     = 3'h1,
    MODE_IN_PD  = 3'h2,
    MODE_ANALOG = 3'h3,
    MODE_PP     = 3'h4,
    MODE_OD     = 3'h5,
    MODE_OD_PU  = 3'h6
  } pin_mode_t;

endpackage : port_cfg_pkg

// [hw/pin_cell.sv]
// one pad: input synchroniser and registered driver, output enable and pull controls
module pin_cell
  import port_cfg_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      resetn_i,
  input  wire pin_mode_t mode_i,
  input  wire logic      data_i,
  input  wire logic      pad_in_i,
  output logic           pad_out_o,
  output logic           pad_oe_o,
  output logic           pullup_o,
  output logic           pulldown_o,
  output logic           analog_en_o,
  output logic           pin_o
);

  logic sync1_q;
  logic sync2_q;
  logic drive_pp;
  logic drive_od;

  // open drain only ever pulls low; a high level is left to the pull or the board
  assign drive_pp = (mode_i == MODE_PP);
  assign drive_od = (mode_i == MODE_OD) || (mode_i == MODE_OD_PU);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q     <= 1'b0;
      sync2_q     <= 1'b0;
      pad_out_o   <= 1'b0;
      pad_oe_o    <= 1'b0;
      pullup_o    <= 1'b0;
      pulldown_o  <= 1'b0;
      analog_en_o <= 1'b0;
      pin_o       <= 1'b0;
    end else begin
      sync1_q     <= pad_in_i;
      sync2_q     <= sync1_q;
      pad_out_o   <= drive_pp & data_i;
      pad_oe_o    <= drive_pp | (drive_od & ~data_i);
      pullup_o    <= (mode_i == MODE_IN_PU) || (mode_i == MODE_OD_PU);
      pulldown_o  <= (mode_i == MODE_IN_PD);
      analog_en_o <= (mode_i == MODE_ANALOG);
      // schmitt input is off in analog mode, so the digital value reads low
      pin_o       <= (mode_i == MODE_ANALOG) ? 1'b0 : sync2_q;
    end
  end

endmodule : pin_cell

// [hw/ext_irq_edge.sv]
// falling-edge detector and sticky pending flag for one external interrupt pin
module ext_irq_edge (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic pad_in_i,
  input  wire logic edge_en_i,
  input  wire logic clear_i,
  output logic      pending_o
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic fall;

  // prev_q starts high, so a pin held low through reset gives an edge once sync2_q falls
  assign fall = prev_q & ~sync2_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q   <= 1'b1;
      sync2_q   <= 1'b1;
      prev_q    <= 1'b1;
      pending_o <= 1'b0;
    end else begin
      sync1_q <= pad_in_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      // a new edge wins over a clear in the same cycle
      if (fall && edge_en_i) begin
        pending_o <= 1'b1;
      end else if (clear_i) begin
        pending_o <= 1'b0;
      end
    end
  end

endmodule : ext_irq_edge

// [dv/pad_board.sv]
// board-side model of the pads: external pulls and the level the input buffers see
module pad_board #(
  parameter int W = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] pu_i,
  input  wire logic [W-1:0] pd_i,
  output logic      [W-1:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] flt_q;

  // a released pad wanders every cycle, so no check can lean on its old level
  always @(posedge clk_sys_i) begin
    if (flt_q == '0)
      flt_q <= '1;
    else
      flt_q <= '0;
  end

  always_comb begin
    for (int k = 0; k < W; k++) begin
      if (oe_i[k])
        pad_o[k] = out_i[k];
      else if (pu_i[k])
        pad_o[k] = 1'b1;
      else if (pd_i[k])
        pad_o[k] = 1'b0;
      else
        pad_o[k] = flt_q[k];
    end
  end
endmodule : pad_board

// [dv/port_pin_config_chk.sv]
// assertion checker on the ports of the pin configuration block
module port_pin_config_chk
  import port_cfg_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] port0_pad_in_i,
  input wire logic [6:0] port2_pad_out_o,
  input wire logic [6:0] port2_pad_oe_o,
  input wire logic [6:0] port2_pullup_o,
  input wire logic [6:0] port2_pin_o,
  input wire logic       analog_input_eight_en_o,
  input wire logic       ext_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------
  // recent falling edges on the interrupt pads
  // ----------------------------------------------------------------
  logic [1:0] pad_q;
  logic [5:0] fall_q;
  wire  logic fall_now = |(pad_q & ~port0_pad_in_i);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_q  <= 2'h3;
      fall_q <= 6'h00;
    end else begin
      pad_q  <= port0_pad_in_i;
      fall_q <= {fall_q[4:0], fall_now};
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_wr(a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence s_rd(a);
    reg_rd_i && !reg_wr_i && reg_addr_i == a;
  endsequence
  property p_back(a, m);
    s_wr(a) ##1 s_rd(a) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & m);
  endproperty

  chk_p1_back: assert property (p_back(OFS_PORT1_CONFIG, MASK_PORT1_CONFIG))
    else $error("port 1 configuration readback wrong");
  chk_p2h_back: assert property (p_back(OFS_PORT2_CONFIG_HIGH, MASK_PORT2_CONFIG_HIGH))
    else $error("port 2 high configuration readback wrong");
  chk_p2l_back: assert property (p_back(OFS_PORT2_CONFIG_LOW, MASK_PORT2_CONFIG_LOW))
    else $error("port 2 low configuration readback wrong");
  chk_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < OFS_PORT0_EXT_IRQ_CTRL
      || reg_addr_i > OFS_PORT2_CONFIG_LOW) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_irq_readback: assert property (s_rd(OFS_PORT0_EXT_IRQ_CTRL) ##0 ext_irq_o |=>
      (reg_rdata_o[0] & reg_rdata_o[1]) | (reg_rdata_o[2] & reg_rdata_o[3]))
    else $error("request without enabled pending bit");
  chk_irq_cleared: assert property (s_wr(OFS_PORT0_EXT_IRQ_CTRL) ##0
      reg_wdata_i[3:0] == 4'h0 |=> !ext_irq_o)
    else $error("request survives clear");
  chk_irq_cause: assert property ($rose(ext_irq_o) |->
      $past(reg_wr_i) || fall_q != 6'h00)
    else $error("request without pad fall");
  chk_irq_stays: assert property (ext_irq_o &&
      !(reg_wr_i && reg_addr_i == OFS_PORT0_EXT_IRQ_CTRL) |=> ext_irq_o)
    else $error("request dropped without write");
  chk_od_low: assert property ((port2_pad_oe_o & port2_pullup_o & port2_pad_out_o) == 7'h00)
    else $error("open drain drives high");
  chk_analog_off: assert property (analog_input_eight_en_o |->
      !port2_pad_oe_o[6] && !port2_pullup_o[6] && !port2_pin_o[6])
    else $error("analog pin not released");
endmodule : port_pin_config_chk

// [dv/testbench.sv]
// self-checking bench for the port pin configuration block
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("CHECK FAILED t=%0t line %0d got %h exp %h", $time, `__LINE__, g, e); \
  end \
end

module testbench
  import port_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys, resetn, wr, rd, tmr, clko, ana, irq;
  logic [7:0] addr, wdata, rdata, p0_cfg, d;
  logic [1:0] p0_pad, p1_data, p1_pad, p1_out, p1_oe, p1_pu, p1_pd, p1_pin;
  logic [6:0] p2_data, p2_pad, p2_out, p2_oe, p2_pu, p2_pin;
  logic [7:0] m_cfg [3];
  logic [1:0] m_en, m_pend;
  int         failures, n_tests;
  // op in [9:8]: 0 write E8, 1 pad fall, 2 port 0 configuration
  logic [9:0] irq_ops [20] = '{10'h0FF, 10'h100, 10'h00F, 10'h00E, 10'h101, 10'h007,
    10'h00F, 10'h00B, 10'h002, 10'h101, 10'h008, 10'h100, 10'h20E, 10'h00A, 10'h100,
    10'h101, 10'h204, 10'h100, 10'h101, 10'h0F0};

  port_pin_config i_port_pin_config (
    .clk_sys_i(clk_sys), .resetn_i(resetn), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .port0_pad_in_i(p0_pad),
    .port0_config_low_i(p0_cfg), .port1_data_i(p1_data), .port2_data_i(p2_data),
    .timer_zero_match_i(tmr), .clock_output_i(clko), .port1_pad_in_i(p1_pad),
    .port1_pad_out_o(p1_out), .port1_pad_oe_o(p1_oe), .port1_pullup_o(p1_pu),
    .port1_pulldown_o(p1_pd), .port1_pin_o(p1_pin), .port2_pad_in_i(p2_pad),
    .port2_pad_out_o(p2_out), .port2_pad_oe_o(p2_oe), .port2_pullup_o(p2_pu),
    .port2_pin_o(p2_pin), .analog_input_eight_en_o(ana), .ext_irq_o(irq));
  pad_board #(.W(2)) i_board1 (.clk_sys_i(clk_sys), .oe_i(p1_oe), .out_i(p1_out),
    .pu_i(p1_pu), .pd_i(p1_pd), .pad_o(p1_pad));
  pad_board #(.W(7)) i_board2 (.clk_sys_i(clk_sys), .oe_i(p2_oe), .out_i(p2_out),
    .pu_i(p2_pu), .pd_i(7'h00), .pad_o(p2_pad));

  // ----------------------------------------------------------------
  // model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] m_read(input logic [7:0] a);
    if (a == OFS_PORT0_EXT_IRQ_CTRL)
      return {4'h0, m_en[1], m_pend[1], m_en[0], m_pend[0]};
    if (a >= OFS_PORT1_CONFIG && a <= OFS_PORT2_CONFIG_LOW)
      return m_cfg[a - OFS_PORT1_CONFIG];
    return 8'h00;
  endfunction : m_read

  // {oe, out, pull-up, pull-down or analog}; kind 0 port 1, 2 pin 0, 3 pin 6
  function automatic logic [3:0] pin_exp(input int kind, input logic [2:0] c,
                                         input logic dat, input logic alt);
    if (kind == 3)
      case (c)
        3'h0: return 4'b0010;
        3'h2, 3'h3: return 4'b0001;
        3'h4: return {1'b1, dat, 2'b00};
        3'h5: return {~dat, 3'b010};
        3'h6: return {~dat, 3'b000};
        3'h7: return {1'b1, alt, 2'b00};
        default: return 4'b0000;
      endcase
    if (kind == 0)
      case (c[1:0])
        2'h1: return 4'b0010;
        2'h2: return c[2] ? {~dat, 3'b000} : {1'b1, dat, 2'b00};
        2'h3: return 4'b0001;
        default: return 4'b0000;
      endcase
    case (c[1:0])
      2'h0: return 4'b0010;
      2'h2: return {1'b1, dat, 2'b00};
      2'h3: return (kind == 2) ? {1'b1, alt, 2'b00} : {~dat, 3'b000};
      default: return 4'b0000;
    endcase
  endfunction : pin_exp

  task automatic rd_only(input logic [7:0] a);
    @(negedge clk_sys);
    addr = a;
    rd   = 1'b1;
    @(negedge clk_sys);
    rd = 1'b0;
    `CHK(rdata, m_read(a))
  endtask : rd_only

  // write then read back in the very next cycle
  task automatic access(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] msk [3];
    msk = '{MASK_PORT1_CONFIG, MASK_PORT2_CONFIG_HIGH, MASK_PORT2_CONFIG_LOW};
    @(negedge clk_sys);
    addr  = a;
    wdata = v;
    wr    = 1'b1;
    @(negedge clk_sys);
    wr = 1'b0;
    rd = 1'b1;
    if (a == OFS_PORT0_EXT_IRQ_CTRL) begin
      m_en   = {v[3], v[1]};
      m_pend = m_pend & {v[2], v[0]};
    end else if (a >= OFS_PORT1_CONFIG && a <= OFS_PORT2_CONFIG_LOW) begin
      m_cfg[a - OFS_PORT1_CONFIG] = v & msk[a - OFS_PORT1_CONFIG];
    end
    @(negedge clk_sys);
    rd = 1'b0;
    `CHK(rdata, m_read(a))
    `CHK(irq, |(m_en & m_pend))
  endtask : access

  task automatic fall(input int k);
    @(negedge clk_sys);
    p0_pad[k] = 1'b0;
    @(negedge clk_sys);
    `CHK(irq, |(m_en & m_pend))
    repeat (4) @(negedge clk_sys);
    if (m_en[k] && !p0_cfg[2 * k + 1])
      m_pend[k] = 1'b1;
    p0_pad[k] = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(irq, |(m_en & m_pend))
  endtask : fall

  task automatic check_pins;
    logic [3:0] e;
    logic [2:0] c;
    for (int k = 0; k < 2; k++) begin
      e = pin_exp(0, {m_cfg[0][6 + k], m_cfg[0][2 * k +: 2]}, p1_data[k], 1'b0);
      `CHK({p1_oe[k], p1_out[k], p1_pu[k], p1_pd[k]}, e)
      if (|{e[3], e[1:0]})
        `CHK(p1_pin[k], e[3] ? e[2] : e[1])
    end
    for (int j = 0; j < 7; j++) begin
      c = (j == 6) ? m_cfg[1][6:4] : {1'b0, m_cfg[j > 3 ? 1 : 2][(2 * j) % 8 +: 2]};
      e = pin_exp((j == 6) ? 3 : (j == 0) ? 2 : 1, c, p2_data[j], (j == 0) ? tmr : clko);
      `CHK({p2_oe[j], p2_out[j], p2_pu[j], j == 6 ? ana : 1'b0}, e)
      if (|{e[3], e[1:0]})
        `CHK(p2_pin[j], e[3] ? e[2] : e[1])
    end
  endtask : check_pins

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end

  initial begin
    {resetn, wr, rd, tmr, clko, addr, wdata, p0_cfg, p1_data, p2_data} = '0;
    p0_pad = 2'h3;
    m_cfg  = '{8'h00, 8'h00, 8'h00};
    m_en   = 2'h0;
    m_pend = 2'h0;
    void'($urandom(45424));
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    for (int r = 8'hE7; r <= 8'hEC; r++)
      rd_only(8'(r));
    check_pins();
    // first half sweeps every code, second half is random
    for (int i = 0; i < 16; i++) begin
      d = {i[2], ~i[2], 2'h3, i[1:0], i[1:0] + 2'h1};
      access(OFS_PORT1_CONFIG, (i < 8) ? d : 8'($urandom));
      d = {1'b1, i[2:0], i[1:0], i[1:0] + 2'h2};
      access(OFS_PORT2_CONFIG_HIGH, (i < 8) ? d : 8'($urandom));
      d = {i[1:0], i[1:0] + 2'h1, i[1:0] + 2'h2, i[1:0] + 2'h3};
      access(OFS_PORT2_CONFIG_LOW, (i < 8) ? d : 8'($urandom));
      @(negedge clk_sys);
      p1_data = 2'($urandom);
      p2_data = 7'($urandom);
      tmr     = 1'($urandom);
      clko    = 1'($urandom);
      repeat (6) @(negedge clk_sys);
      check_pins();
    end
    access(8'hE7, 8'($urandom));
    access(8'hEC, 8'($urandom));
    foreach (irq_ops[i]) begin
      case (irq_ops[i][9:8])
        2'h0: access(OFS_PORT0_EXT_IRQ_CTRL, irq_ops[i][7:0]);
        2'h1: fall(int'(irq_ops[i][0]));
        default: p0_cfg = irq_ops[i][7:0];
      endcase
    end
    give_verdict();
  end
endmodule : testbench

bind port_pin_config port_pin_config_chk i_port_pin_config_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .port0_pad_in_i(port0_pad_in_i),
  .port2_pad_out_o(port2_pad_out_o), .port2_pad_oe_o(port2_pad_oe_o),
  .port2_pullup_o(port2_pullup_o), .port2_pin_o(port2_pin_o),
  .analog_input_eight_en_o(analog_input_eight_en_o), .ext_irq_o(ext_irq_o));
